// >>> bench/ssp_host_model.sv
`default_nettype none

// --
// management host on the command port
// --
module ssp_host_model (
	// clock
	input wire logic clk,
	// command port
	output logic cmdValid,
	output logic cmdWrite,
	output logic [7:0] cmdCode,
	output logic [15:0] cmdWdata,
	input wire logic rdValid,
	input wire logic [55:0] rdData
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {cmdValid, cmdWrite, cmdCode, cmdWdata} = '0;

	// strobe stands for the one taking edge; the answer stands one cycle, so catch it then
	// setup writes go out with conversion off, except where a refusal is wanted
	task automatic issue(input logic wr, input logic [7:0] code, input logic [15:0] wd,
		output logic ok, output logic [55:0] rd);
		@(posedge clk);
		cmdValid <= 1'b1;
		cmdWrite <= wr;
		cmdCode <= code;
		cmdWdata <= wd;
		@(posedge clk);
		cmdValid <= 1'b0;
		#1;
		ok = rdValid;
		rd = rdData;
	endtask : issue
endmodule : ssp_host_model

`default_nettype wire

// >>> bench/ssp_status_monitor.sv
`default_nettype none

// --
// port checker for the status and power-good block
// --
module ssp_status_monitor (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// command port
	input wire logic cmdValid,
	input wire logic cmdWrite,
	input wire logic [7:0] cmdCode,
	input wire logic rdValid,
	// sequence state
	input wire logic convEnabled,
	input wire logic inToffFall,
	input wire logic inFaultShutdown,
	// watched outputs
	input wire logic powerGoodOut,
	input wire logic smbAlert_n,
	input wire logic invalidCommandFlag,
	input wire logic statusByteCml,
	input wire logic [15:0] powerGoodSetup
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic roWr;
	logic clrWr;
	// decoded writes, kept combinational so the checks line up with the taking edge
	assign roWr = cmdValid && cmdWrite && cmdCode == 8'hdb;
	assign clrWr = cmdValid && cmdWrite && cmdCode == 8'h03;

	a_ro_write_flag: assert property (roWr |=> invalidCommandFlag && statusByteCml)
		else $error("read-only write not flagged");
	a_alert_low: assert property (roWr |=> !smbAlert_n)
		else $error("alert not raised");
	a_flag_sticky: assert property (invalidCommandFlag && !clrWr |=> invalidCommandFlag)
		else $error("status flag cleared");
	a_read_answer: assert property (cmdValid && !cmdWrite |=> rdValid)
		else $error("read not answered");
	a_reply_cause: assert property (rdValid |-> $past(cmdValid) && !$past(cmdWrite))
		else $error("answer without read");
	a_pg_off: assert property (!convEnabled |=> !powerGoodOut)
		else $error("power good high while off");
	a_pg_fast_off: assert property (inToffFall || inFaultShutdown |=> !powerGoodOut)
		else $error("power good not dropped at once");
	a_setup_locked: assert property ($past(convEnabled) |-> $stable(powerGoodSetup))
		else $error("setup changed while enabled");
	a_pg_rise_clean: assert property ($rose(powerGoodOut) |-> !$past(inToffFall))
		else $error("power good rose while falling");

	c_read: cover property (rdValid);
	c_pg_rise: cover property ($rose(powerGoodOut));
	c_refused: cover property (roWr ##1 !smbAlert_n);
endmodule : ssp_status_monitor

bind ssp_status_pg ssp_status_monitor u_mon (.clk, .rst_n, .cmdValid, .cmdWrite, .cmdCode,
	.rdValid, .convEnabled, .inToffFall, .inFaultShutdown, .powerGoodOut, .smbAlert_n,
	.invalidCommandFlag, .statusByteCml, .powerGoodSetup);

`default_nettype wire

// >>> bench/tb_top.sv
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst_n, pwmClk, cmdValid, cmdWrite, rdValid, convEnabled;
	logic inTonDelay, inTonRise, inToffFall, inFaultShutdown;
	logic powerGoodOut, smbAlert_n, invalidCommandFlag, statusByteCml;
	logic [7:0] cmdCode, phaseSel, pgEvents, pgContinue;
	logic [7:0] vendorStatusByte, statusOther, statusCml, statusTemp, statusInput, statusIout;
	logic [7:0] statusVout;
	logic [15:0] cmdWdata, pgSetupNvm, powerGoodSetup;
	logic [55:0] rdData, rdv;
	logic [1:0] stackPhases;
	logic [3:0] phaseFaultIn, phaseAnyStatus;
	int n_mismatch = 0;
	int num_checks = 0;
	int cyc = 0;

	ssp_status_pg uut (.clk, .rst_n, .pwmClk, .cmdValid, .cmdWrite, .cmdCode, .cmdWdata,
		.phaseSel, .rdValid, .rdData, .vendorStatusByte, .statusOther, .statusCml, .statusTemp,
		.statusInput, .statusIout, .statusVout, .stackPhases, .phaseFaultIn, .phaseAnyStatus,
		.pgSetupNvm, .convEnabled, .inTonDelay, .inTonRise, .inToffFall, .inFaultShutdown,
		.pgEvents, .pgContinue, .powerGoodOut, .smbAlert_n, .invalidCommandFlag,
		.statusByteCml, .powerGoodSetup);
	ssp_host_model host (.clk, .cmdValid, .cmdWrite, .cmdCode, .cmdWdata, .rdValid, .rdData);

	// --
	// clocks and hang guard
	// --
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// switching clock free-runs at 64 ns, phased off the system edges
	initial
	begin
		pwmClk = 1'b0;
		#1;
		forever #32 pwmClk = ~pwmClk;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	// --
	// shared tasks
	// --
	task automatic chk(input bit ok);
		num_checks++;
		if (!ok)
		begin
			n_mismatch++;
			$display("Error at %0t: port value differs from expected", $time);
		end
	endtask : chk
	task automatic cmd(input logic wr, input logic [7:0] c, input logic [15:0] w);
		logic ok;
		host.issue(wr, c, w, ok, rdv);
		chk(ok === ~wr);
	endtask : cmd
	// bounded wait; a stuck power-good stops after 200 cycles
	task automatic wait_pg(input logic v, output int n);
		n = 0;
		while (powerGoodOut !== v && n < 200)
		begin
			@(posedge clk);
			#1;
			n++;
		end
	endtask : wait_pg

	// --
	// scenarios
	// --
	task automatic t_aggregate;
		cmd(1'b0, 8'hdb, 16'h0000);
		chk(rdv === 56'h11223344556677);
		cmd(1'b1, 8'hdb, 16'hffff);
		chk(invalidCommandFlag === 1'b1 && statusByteCml === 1'b1);
		chk(smbAlert_n === 1'b0);
		cmd(1'b0, 8'hdb, 16'h0000);
		chk(rdv === 56'h1122b344556677);
		cmd(1'b1, 8'h03, 16'h0000);
		chk(smbAlert_n === 1'b1 && invalidCommandFlag === 1'b0);
	endtask : t_aggregate
	task automatic t_phase;
		@(posedge clk);
		stackPhases <= 2'h1;
		phaseFaultIn <= 4'h6;
		phaseAnyStatus <= 4'ha;
		phaseSel <= 8'hff;
		@(posedge clk);
		phaseFaultIn <= 4'h0;
		cmd(1'b0, 8'hdc, 16'h0000);
		chk(rdv === 56'h2);
		@(posedge clk);
		phaseSel <= 8'h01;
		cmd(1'b0, 8'hdc, 16'h0000);
		chk(rdv === 56'h1);
		@(posedge clk);
		phaseSel <= 8'h03;
		cmd(1'b0, 8'hdc, 16'h0000);
		chk(rdv === 56'h0);
		// writing zeros clears the sticky phase bits
		cmd(1'b1, 8'hdc, 16'h0000);
		@(posedge clk);
		phaseSel <= 8'hff;
		cmd(1'b0, 8'hdc, 16'h0000);
		chk(rdv === 56'h0);
	endtask : t_phase
	// assert code 1 is 3 ticks, release code 0 is 1 tick, output overvoltage fault masked
	task automatic t_power;
		int n;
		cmd(1'b1, 8'he3, 16'h1080);
		chk(powerGoodSetup === 16'h1080);
		cmd(1'b0, 8'he3, 16'h0000);
		chk(rdv === 56'h1080);
		@(posedge clk);
		convEnabled <= 1'b1;
		wait_pg(1'b1, n);
		chk(n > 0 && n < 40);
		@(posedge clk);
		pgEvents <= 8'h84;
		pgContinue <= 8'h04;
		repeat (100) @(posedge clk);
		chk(powerGoodOut === 1'b1);
		pgContinue <= 8'h00;
		repeat (20) @(posedge clk);
		pgContinue <= 8'h04;
		repeat (100) @(posedge clk);
		chk(powerGoodOut === 1'b1);
		pgContinue <= 8'h00;
		wait_pg(1'b0, n);
		chk(n > 30 && n < 60);
		@(posedge clk);
		pgEvents <= 8'h00;
		wait_pg(1'b1, n);
		chk(powerGoodOut === 1'b1 && n < 40);
		cmd(1'b1, 8'he3, 16'h0000);
		chk(powerGoodSetup === 16'h1080 && invalidCommandFlag === 1'b1);
		@(posedge clk);
		inToffFall <= 1'b1;
		@(posedge clk);
		#1;
		chk(powerGoodOut === 1'b0);
	endtask : t_power
	// ton delay, ton rise and fault shutdown each force power good low on the next edge, then conversion off does
	task automatic t_sequence;
		int n;
		for (int k = 0; k < 3; k++)
		begin
			@(posedge clk);
			{inToffFall, inFaultShutdown, inTonDelay, inTonRise} <= 4'h0;
			wait_pg(1'b1, n);
			chk(powerGoodOut === 1'b1);
			@(posedge clk);
			{inFaultShutdown, inTonDelay, inTonRise} <= 3'(1 << k);
			@(posedge clk);
			#1;
			chk(powerGoodOut === 1'b0);
		end
		@(posedge clk);
		{inFaultShutdown, inTonDelay, inTonRise} <= 3'h0;
		wait_pg(1'b1, n);
		chk(powerGoodOut === 1'b1);
		@(posedge clk);
		convEnabled <= 1'b0;
		@(posedge clk);
		#1;
		chk(powerGoodOut === 1'b0);
	endtask : t_sequence

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : tally_and_finish

	initial
	begin
		{vendorStatusByte, statusOther, statusCml, statusTemp} = 32'h11223344;
		{statusInput, statusIout, statusVout} = 24'h556677;
		{rst_n, convEnabled, inTonDelay, inTonRise, inToffFall, inFaultShutdown} = '0;
		{phaseSel, pgEvents, pgContinue, stackPhases, phaseFaultIn, phaseAnyStatus} = '0;
		pgSetupNvm = 16'h2345;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		chk(powerGoodSetup === 16'h2345);
		t_aggregate();
		t_phase();
		t_power();
		t_sequence();
		tally_and_finish();
	end
endmodule : tb_top

`default_nettype wire

// >>> logic/ssp_pg_delay.sv
`default_nettype none

// one power-good delay timer, counts switching ticks while run holds
module ssp_pg_delay #(
	parameter int CNT_W = ssp_pkg::DELAY_CNT_W
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// control
	input wire logic tick,
	input wire logic run,
	input wire logic [ssp_pkg::DLY_FIELD_W-1:0] code,
	// result
	output logic done
);

	// the longest code needs 2^15+1 ticks; counters narrower than DELAY_CNT_W are refused
	if (CNT_W < ssp_pkg::DELAY_CNT_W)
		$error("ssp_pg_delay: CNT_W too small for the longest delay");

	typedef struct packed {
		logic [CNT_W-1:0] count;
		logic done;
	} ssp_delay_state_t;

	ssp_delay_state_t s_q;
	ssp_delay_state_t s_d;
	logic [CNT_W-1:0] target;
	logic [CNT_W-1:0] countInc;

	// ----------------------------------------
	// target and next state
	// ----------------------------------------
	// code 0 is one tick, otherwise 2^N+1 ticks
	always_comb
	begin
		target = (code == '0) ? CNT_W'(1) : ((CNT_W'(1) << code) + CNT_W'(1)); // [R9] [R10]
		countInc = s_q.count + CNT_W'(1);
		s_d = s_q;
		if (!run)
		begin
			s_d.count = '0; // restart whenever the condition drops [R20]
			s_d.done = 1'b0;
		end
		else if (tick && !s_q.done)
		begin
			s_d.count = countInc; // one step per switching tick [R20]
			s_d.done = (countInc >= target);
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign done = s_q.done;

endmodule : ssp_pg_delay

`default_nettype wire

// >>> logic/ssp_status_pg.sv
`default_nettype none

// status summary reads and power-good qualification
module ssp_status_pg #(
	parameter int PHASES = ssp_pkg::PHASE_MAX
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// switching-period clock from the modulator, asynchronous here
	input wire logic pwmClk,
	// command port
	input wire logic cmdValid,
	input wire logic cmdWrite,
	input wire logic [7:0] cmdCode,
	input wire logic [15:0] cmdWdata,
	input wire logic [7:0] phaseSel,
	output logic rdValid,
	output logic [55:0] rdData,
	// status bytes from the rest of the device
	input wire logic [7:0] vendorStatusByte,
	input wire logic [7:0] statusOther,
	input wire logic [7:0] statusCml,
	input wire logic [7:0] statusTemp,
	input wire logic [7:0] statusInput,
	input wire logic [7:0] statusIout,
	input wire logic [7:0] statusVout,
	// stack
	input wire logic [1:0] stackPhases,
	input wire logic [PHASES-1:0] phaseFaultIn,
	input wire logic [PHASES-1:0] phaseAnyStatus,
	// nonvolatile default for the power-good setup
	input wire logic [15:0] pgSetupNvm,
	// converter sequence state
	input wire logic convEnabled,
	input wire logic inTonDelay,
	input wire logic inTonRise,
	input wire logic inToffFall,
	input wire logic inFaultShutdown,
	// fault and warning events, laid out as the mask bits
	input wire logic [7:0] pgEvents,
	input wire logic [7:0] pgContinue,
	// outputs
	output logic powerGoodOut,
	output logic smbAlert_n,
	output logic invalidCommandFlag,
	output logic statusByteCml,
	output logic [15:0] powerGoodSetup
);

	// the summary word holds four phase bits only
	if (PHASES < 1 || PHASES > ssp_pkg::PHASE_MAX)
		$error("ssp_status_pg: PHASES must be 1 to 4");

	typedef struct packed {
		logic [1:0] pwmSync;
		logic pwmPrev;
		logic cfgLoaded;
		logic [15:0] pgSetup;
		logic [PHASES-1:0] phaseLatch;
		logic ivcFlag;
		logic cmlBit;
		logic alert_n;
		logic pgOut;
		logic rdValid;
		logic [55:0] rdData;
	} ssp_core_state_t;

	ssp_core_state_t s_q;
	ssp_core_state_t s_d;

	logic pwmTick;
	logic qualified;
	logic forcedLow;
	logic bypassLow;
	logic assertDone;
	logic releaseDone;
	logic [PHASES-1:0] phaseUsed;
	logic [PHASES-1:0] phaseSummary;
	logic [15:0] phaseWord;
	logic [55:0] aggregate;
	logic [7:0] cmlMerged;
	logic isRead;
	logic isWrite;

	// ----------------------------------------
	// phase bookkeeping
	// ----------------------------------------
	// a phase counts as used only up to the configured stack size
	for (genvar p = 0; p < PHASES; p++)
	begin : g_phase
		assign phaseUsed[p] = (p <= int'(stackPhases));
		assign phaseSummary[p] = s_q.phaseLatch[p] & phaseUsed[p]; // [R7] [R8]
	end

	// ----------------------------------------
	// read data
	// ----------------------------------------
	always_comb
	begin
		phaseWord = '0; // reserved bits stay zero [R7]
		if (phaseSel == ssp_pkg::PHASE_ALL)
			phaseWord[PHASES-1:0] = phaseSummary; // [R5]
		else if (phaseSel < 8'(PHASES) && phaseUsed[phaseSel[1:0]])
			phaseWord[0] = phaseAnyStatus[phaseSel[1:0]]; // [R6]
		else
			phaseWord = '0; // unassigned phase reads zero [R7]
		cmlMerged = statusCml;
		cmlMerged[ssp_pkg::IVC_BIT] = statusCml[ssp_pkg::IVC_BIT] | s_q.ivcFlag;
		aggregate = {vendorStatusByte, statusOther, cmlMerged, statusTemp,
			statusInput, statusIout, statusVout}; // [R1]
	end

	// ----------------------------------------
	// power-good qualification
	// ----------------------------------------
	// a set mask bit hides the event; continue-uninterrupted faults are dropped too
	assign qualified = |(pgEvents & ~s_q.pgSetup[ssp_pkg::MASK_W-1:0] & ~pgContinue); // [R11] [R12] [R13] [R18]
	assign forcedLow = !convEnabled || inTonDelay || inTonRise; // [R16]
	assign bypassLow = inToffFall || inFaultShutdown; // [R17]
	// edge of the synchronised switching clock; stage 0 is read only by stage 1
	assign pwmTick = s_q.pwmSync[1] & ~s_q.pwmPrev;
	assign isRead = cmdValid && !cmdWrite;
	assign isWrite = cmdValid && cmdWrite;

	// ----------------------------------------
	// independent delay timers
	// ----------------------------------------
	ssp_pg_delay #(
		.CNT_W(ssp_pkg::DELAY_CNT_W)
	) u_assertTimer (
		.clk(clk),
		.rst_n(rst_n),
		.tick(pwmTick),
		.run(qualified && s_q.pgOut), // [R19]
		.code(s_q.pgSetup[ssp_pkg::ASSERT_DLY_LSB +: ssp_pkg::DLY_FIELD_W]), // [R9]
		.done(assertDone)
	);

	ssp_pg_delay #(
		.CNT_W(ssp_pkg::DELAY_CNT_W)
	) u_releaseTimer (
		.clk(clk),
		.rst_n(rst_n),
		.tick(pwmTick),
		.run(!qualified && !s_q.pgOut && !forcedLow && !bypassLow), // [R19]
		.code(s_q.pgSetup[ssp_pkg::RELEASE_DLY_LSB +: ssp_pkg::DLY_FIELD_W]), // [R10]
		.done(releaseDone)
	);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb
	begin
		s_d = s_q;
		s_d.pwmSync = {s_q.pwmSync[0], pwmClk};
		s_d.pwmPrev = s_q.pwmSync[1];

		// nonvolatile default taken once, the cycle after reset release
		if (!s_q.cfgLoaded)
		begin
			s_d.pgSetup = pgSetupNvm; // [R15]
			s_d.cfgLoaded = 1'b1;
		end

		// phase latches: hardware set wins over a host clear in the same cycle
		if (isWrite && cmdCode == ssp_pkg::CMD_PHASE)
			s_d.phaseLatch = s_q.phaseLatch & cmdWdata[PHASES-1:0];
		s_d.phaseLatch = s_d.phaseLatch | phaseFaultIn; // [R8]

		// clear-faults drops the communication flags; a new refusal still wins
		if (isWrite && cmdCode == ssp_pkg::CMD_CLEAR_FAULTS)
		begin
			s_d.ivcFlag = 1'b0;
			s_d.cmlBit = 1'b0;
		end
		// aggregate is read-only; the write clears no status bit, it only sets the refusal flags [R4]
		if (isWrite && cmdCode == ssp_pkg::CMD_AGGREGATE)
		begin
			s_d.ivcFlag = 1'b1; // [R2]
			s_d.cmlBit = 1'b1; // [R2]
		end
		// setup is read-only while converting, so the write is refused
		if (isWrite && cmdCode == ssp_pkg::CMD_PG_SETUP)
		begin
			if (!convEnabled && s_q.cfgLoaded)
				s_d.pgSetup = cmdWdata; // [R14]
			else if (convEnabled)
			begin
				s_d.ivcFlag = 1'b1; // [R14] [R2]
				s_d.cmlBit = 1'b1;
			end
		end
		s_d.alert_n = !(s_d.ivcFlag || s_d.cmlBit); // [R3]

		// read answer one cycle after the request
		s_d.rdValid = isRead;
		if (isRead)
		begin
			unique case (cmdCode)
				ssp_pkg::CMD_AGGREGATE: s_d.rdData = aggregate; // [R1]
				ssp_pkg::CMD_PHASE: s_d.rdData = {40'h0, phaseWord}; // [R5] [R6]
				ssp_pkg::CMD_PG_SETUP: s_d.rdData = {40'h0, s_q.pgSetup};
				default: s_d.rdData = '0;
			endcase
		end

		// power good: forced low states win, then the timers decide
		if (forcedLow || bypassLow)
			s_d.pgOut = 1'b0; // [R16] [R17]
		else if (s_q.pgOut && assertDone)
			s_d.pgOut = 1'b0; // [R9] [R19]
		else if (!s_q.pgOut && releaseDone)
			s_d.pgOut = 1'b1; // [R10] [R19]
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			s_q <= '0;
			s_q.pgSetup <= ssp_pkg::PG_SETUP_RESET;
			s_q.alert_n <= 1'b1;
		end
		else
			s_q <= s_d;
	end

	// ----------------------------------------
	// outputs, all straight from flops
	// ----------------------------------------
	assign rdValid = s_q.rdValid;
	assign rdData = s_q.rdData;
	assign powerGoodOut = s_q.pgOut;
	assign smbAlert_n = s_q.alert_n;
	assign invalidCommandFlag = s_q.ivcFlag;
	assign statusByteCml = s_q.cmlBit;
	assign powerGoodSetup = s_q.pgSetup;

endmodule : ssp_status_pg

`default_nettype wire

// >>> shared/ssp_pkg.sv
// Behaviour
// (R1) aggregate read returns seven status bytes, vendor first
// (R2) write to read-only command flags invalid command
// (R3) invalid command raises the bus alert line
// (R4) aggregate write never clears asserted status bits
// (R5) all-phases selector returns one fault bit per phase
// (R6) single phase selector returns bit 0 on status
// (R7) unused phases and bits 15:4 read zero
// (R8) summary bits 3..0 map to phases 3..0
// (R9) assert delay field 15:12, 1 or 2^N+1 ticks
// (R10) release delay field 11:8, 1 or 2^N+1 ticks
// (R11) mask bits 7..4 gate output voltage events
// (R12) mask bits 3,2 gate output current events
// (R13) mask bits 1,0 gate input overvoltage events
// (R14) setup writable only while conversion is disabled
// (R15) setup reset value taken from nonvolatile defaults
// (R16) power good low when off or sequencing or faulted
// (R17) turn-off fall and shutdown bypass assert delay
// (R18) unmasked faults count unless set to continue uninterrupted
// (R19) assert and release delays use independent counters
// (R20) counters advance per switching tick, restart on change
`default_nettype none

package ssp_pkg;

	// ----------------------------------------
	// command codes
	// ----------------------------------------
	localparam logic [7:0] CMD_AGGREGATE = 8'hdb;
	localparam logic [7:0] CMD_PHASE = 8'hdc;
	localparam logic [7:0] CMD_PG_SETUP = 8'he3;
	localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
	localparam logic [7:0] PHASE_ALL = 8'hff;

	// ----------------------------------------
	// field layout
	// ----------------------------------------
	localparam int AGG_W = 56;
	localparam int WORD_W = 16;
	localparam int IVC_BIT = 7;
	localparam int CML_BYTE_BIT = 1;
	localparam int ASSERT_DLY_LSB = 12;
	localparam int RELEASE_DLY_LSB = 8;
	localparam int DLY_FIELD_W = 4;
	localparam int MASK_W = 8;
	localparam int PHASE_MAX = 4;

	// event and mask bit positions, shared by the event vector and the mask
	localparam int MASK_OUT_OV_FAULT = 7;
	localparam int MASK_OUT_OV_WARN = 6;
	localparam int MASK_OUT_UV_FAULT = 5;
	localparam int MASK_OUT_UV_WARN = 4;
	localparam int MASK_OUT_OC_WARN = 3;
	localparam int MASK_OUT_OC_FAULT = 2;
	localparam int MASK_IN_OV_WARN = 1;
	localparam int MASK_IN_OV_FAULT = 0;

	// ----------------------------------------
	// reset values and timing
	// ----------------------------------------
	localparam logic [15:0] PG_SETUP_RESET = 16'h0000;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam int DELAY_CNT_W = 17;

endpackage : ssp_pkg

`default_nettype wire
